// ==== hdl/fpc_top.sv ====
/*
  Film position panel control: reader display source, set/hold editing,
  store into film position, online/offline gating of motion commands.
  Assumes an AXI4-Lite master on mclk; follower and local switch pins are
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_top
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // remote motion commands (chain master, controller, editor)
  input wire fpc_pkg::fpc_motion_t remote_cmd,
  input wire logic controller_attached,
  // local motion switches (pins)
  input wire logic [2:0] local_switch,
  // follower pulses (pins)
  input wire logic follower_step,
  input wire logic follower_dir,
  // to biphase generator
  output fpc_pkg::fpc_motion_t gen_cmd,
  // indicators and display
  output logic online_led,
  output logic set_hold_led,
  output logic report_local,
  output logic [1:0] reader_view,
  output logic subframe_blank
);
  import fpc_pkg::*;

  // synchronisers for pins
  logic [2:0] sw_meta;
  logic [2:0] sw_sync;
  logic [1:0] fol_meta;
  logic [1:0] fol_sync;
  logic step_prev;
  logic step_pulse;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sw_meta <= 3'h0;
      sw_sync <= 3'h0;
      fol_meta <= 2'h0;
      fol_sync <= 2'h0;
      step_prev <= 1'b0;
    end
    else
    begin
      sw_meta <= local_switch;
      sw_sync <= sw_meta;
      fol_meta <= {follower_dir, follower_step};
      fol_sync <= fol_meta;
      step_prev <= fol_sync[0];
    end
  end

  assign step_pulse = fol_sync[0] && !step_prev;

  // axi4-lite slave
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = aw_addr == fpc_reg_ctrl || aw_addr == fpc_reg_keys || aw_addr == fpc_reg_remote_pos;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // key presses are one-cycle strobes from a write to the keys register
  logic keys_wr;
  logic [6:0] key;
  assign keys_wr = wr_fire && aw_addr == fpc_reg_keys && w_strb[0];
  assign key = keys_wr ? w_data[6:0] : 7'h00;

  // control register
  logic [1:0] rate;
  logic [1:0] speed;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate <= fpc_rate_reset;
      speed <= fpc_spd_stop;
    end
    else if (wr_fire && aw_addr == fpc_reg_ctrl && w_strb[0])
    begin
      // 24, 25 or 30 only; an illegal code keeps the old rate
      if (w_data[fpc_ctrl_rate_lsb +: 2] != 2'h3)
        rate <= w_data[fpc_ctrl_rate_lsb +: 2];
      speed <= w_data[fpc_ctrl_speed_lsb +: 2];
    end
  end

  // online/offline
  logic online;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      online <= 1'b1;
    else if (key[fpc_key_tran_mode])
      online <= !online;
  end

  // reader display selection
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      reader_view <= fpc_view_timecode_source;
    else if (key[fpc_key_dsel] && key[fpc_key_shift])
    begin
      case (reader_view)
        fpc_view_timecode_source: reader_view <= fpc_view_film;
        fpc_view_film: reader_view <= fpc_view_user_bits;
        default: reader_view <= fpc_view_timecode_source;
      endcase
    end
  end

  // set/hold editing
  typedef enum logic {fpc_idle, fpc_edit} fpc_edit_state_t;
  fpc_edit_state_t edit_state;
  logic [1:0] focus;
  fpc_pos_t edit_val;
  fpc_pos_t pos;
  logic [4:0] fps;
  logic store_now;
  logic remote_load;
  assign fps = fpc_fps(rate);
  assign store_now = edit_state == fpc_edit && key[fpc_key_store] && reader_view == fpc_view_film;
  assign remote_load = wr_fire && aw_addr == fpc_reg_remote_pos;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      edit_state <= fpc_idle;
      focus <= 2'h0;
    end
    else
    begin
      case (edit_state)
        fpc_idle:
          if (key[fpc_key_set_hold])
          begin
            edit_state <= fpc_edit;
            focus <= 2'h0;
          end
        fpc_edit:
          if (key[fpc_key_store])
            edit_state <= fpc_idle;
          else if (key[fpc_key_set_hold])
            focus <= (focus == fpc_focus_last) ? 2'h0 : focus + 2'h1;
        default: edit_state <= fpc_idle;
      endcase
    end
  end

  // edit value: captured on entry, stepped by up/down within its digit pair
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      edit_val <= '0;
    else if (edit_state == fpc_idle)
    begin
      edit_val <= pos;
      edit_val.subframes <= 7'h00;
    end
    else if (key[fpc_key_up] ^ key[fpc_key_down])
    begin
      case (focus)
        2'h0: edit_val.hours <= key[fpc_key_up] ?
          ((edit_val.hours == fpc_hours_per_day - 5'h01) ? 5'h00 : edit_val.hours + 5'h01) :
          ((edit_val.hours == 5'h00) ? fpc_hours_per_day - 5'h01 : edit_val.hours - 5'h01);
        2'h1: edit_val.minutes <= key[fpc_key_up] ?
          ((edit_val.minutes == fpc_sec_per_min - 6'h01) ? 6'h00 : edit_val.minutes + 6'h01) :
          ((edit_val.minutes == 6'h00) ? fpc_sec_per_min - 6'h01 : edit_val.minutes - 6'h01);
        2'h2: edit_val.seconds <= key[fpc_key_up] ?
          ((edit_val.seconds == fpc_sec_per_min - 6'h01) ? 6'h00 : edit_val.seconds + 6'h01) :
          ((edit_val.seconds == 6'h00) ? fpc_sec_per_min - 6'h01 : edit_val.seconds - 6'h01);
        default: edit_val.frames <= key[fpc_key_up] ?
          ((edit_val.frames >= fps - 5'h01) ? 5'h00 : edit_val.frames + 5'h01) :
          ((edit_val.frames == 5'h00) ? fps - 5'h01 : edit_val.frames - 5'h01);
      endcase
    end
  end

  // set/hold indicator flashes while editing
  logic [21:0] flash_cnt;
  logic flash;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flash_cnt <= 22'h00_0000;
      flash <= 1'b0;
    end
    else if (edit_state != fpc_edit)
    begin
      flash_cnt <= 22'h00_0000;
      flash <= 1'b0;
    end
    else if (flash_cnt == 22'(fpc_flash_cycles - 1))
    begin
      flash_cnt <= 22'h00_0000;
      flash <= !flash;
    end
    else
      flash_cnt <= flash_cnt + 22'h00_0001;
  end
  assign set_hold_led = edit_state == fpc_edit && !flash;

  // film position; panel store has priority over a remote value
  fpc_pos_t load_pos;
  fpc_pos_t remote_pos;
  always_comb
  begin
    remote_pos = w_data[28:0];
    load_pos = store_now ? edit_val : remote_pos;
  end

  fpc_pos_counter u_pos
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .step(step_pulse),
    .dir_fwd(fol_sync[1]),
    .rate(rate),
    .load(store_now || remote_load),
    .load_pos(load_pos),
    .pos(pos)
  );

  // motion command gating
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      gen_cmd <= '0;
    else if (online)
      gen_cmd <= remote_cmd;
    else
    begin
      // remote commands are dropped; local switches drive the generator
      gen_cmd.valid <= sw_sync != 3'h0;
      gen_cmd.cmd <= sw_sync;
    end
  end

  assign online_led = online;
  assign report_local = !online && controller_attached;
  assign subframe_blank = reader_view == fpc_view_film && speed == fpc_spd_play;

  // read channel
  logic [31:0] rd_data;
  logic rd_ok;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      fpc_reg_ctrl: rd_data = {28'h000_0000, speed, rate};
      fpc_reg_keys: rd_data = 32'h0000_0000;
      fpc_reg_status: rd_data = {24'h00_0000, report_local, focus, reader_view,
        set_hold_led, edit_state == fpc_edit, online};
      fpc_reg_position: rd_data = {3'h0, pos};
      fpc_reg_display: rd_data = edit_state == fpc_edit ? {3'h0, edit_val} :
        {3'h0, pos[28:7], subframe_blank ? 7'h00 : pos.subframes};
      fpc_reg_remote_pos: rd_data = {3'h0, pos};
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// ==== hdl/fpc_pkg.sv ====
/*
  Package for the film position panel control block: register map,
  field positions, reset values, key and mode types.
  Assumes a 10 MHz mclk and an AXI4-Lite master for software access.
*/
// Notes on behaviour
// - shifted display-select in reader view cycles timecode, film position, user bits.
// - film position view shows subframes when stopped or slow, blanks them at play.
// - film position loads from front-panel store or from a controller value.
// - displayed film position uses time code frames matching film frame rate.
// - entry only in set/hold editing; set/hold key enters; indicator flashes.
// - store writes displayed value into selected register, then leaves editing; code writes only in film position view.
// - up/down change selected digit pair; further set/hold moves focus on.
// - transport-mode key toggles online/offline; online indicator shows state.
// - online, generator follows chain master, controller or editor motion commands.
// - offline, generator ignores all remote motion commands.
// - offline, generator still obeys local motion switches.
// - follower tracks movement and updates position whether online or offline.
// - offline with a controller attached, report status as offline/local.
// - film frame rate is 24, 25 or 30 fps.
// - subframes count hundredths of a frame.
package fpc_pkg;

  // register byte offsets
  localparam logic [7:0] fpc_reg_ctrl = 8'h00;
  localparam logic [7:0] fpc_reg_keys = 8'h04;
  localparam logic [7:0] fpc_reg_status = 8'h08;
  localparam logic [7:0] fpc_reg_position = 8'h0C;
  localparam logic [7:0] fpc_reg_display = 8'h10;
  localparam logic [7:0] fpc_reg_remote_pos = 8'h14;

  // ctrl fields
  localparam int fpc_ctrl_rate_lsb = 0;
  localparam int fpc_ctrl_speed_lsb = 2;
  localparam logic [1:0] fpc_rate_reset = 2'h0;

  // keys register bits (write one to press)
  localparam int fpc_key_dsel = 0;
  localparam int fpc_key_shift = 1;
  localparam int fpc_key_set_hold = 2;
  localparam int fpc_key_store = 3;
  localparam int fpc_key_up = 4;
  localparam int fpc_key_down = 5;
  localparam int fpc_key_tran_mode = 6;

  // status bits
  localparam int fpc_st_online = 0;
  localparam int fpc_st_editing = 1;
  localparam int fpc_st_sh_led = 2;
  localparam int fpc_st_view_lsb = 3;
  localparam int fpc_st_focus_lsb = 5;
  localparam int fpc_st_local = 7;

  localparam logic [6:0] fpc_subframes = 7'h64;
  localparam logic [5:0] fpc_sec_per_min = 6'h3C;
  localparam logic [4:0] fpc_hours_per_day = 5'h18;

  // set/hold flash: half period in ms at 10 MHz
  localparam int fpc_flash_ms = 250;
  localparam int fpc_clk_khz = 10000;
  localparam int fpc_flash_cycles = fpc_flash_ms * fpc_clk_khz;
  localparam logic [1:0] fpc_focus_last = 2'h3;

  typedef enum logic [1:0] {fpc_rate_24, fpc_rate_25, fpc_rate_30} fpc_rate_t;
  typedef enum logic [1:0] {fpc_view_timecode_source, fpc_view_film, fpc_view_user_bits} fpc_view_t;
  typedef enum logic [1:0] {fpc_spd_stop, fpc_spd_slow, fpc_spd_play} fpc_speed_t;

  typedef struct packed
  {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
    logic [6:0] subframes;
  } fpc_pos_t;

  typedef struct packed
  {
    logic valid;
    logic [2:0] cmd;
  } fpc_motion_t;

  // frames in one second for a film rate
  function automatic logic [4:0] fpc_fps(input logic [1:0] rate);
    case (rate)
      2'h1: fpc_fps = 5'h19;
      2'h2: fpc_fps = 5'h1E;
      default: fpc_fps = 5'h18;
    endcase
  endfunction

endpackage

// ==== hdl/fpc_pos_counter.sv ====
/*
  Film position counter: steps one subframe per follower pulse with
  rollover through frames, seconds, minutes and hours; loadable.
  Assumes step and direction are already synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_pos_counter
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // follower steps
  input wire logic step,
  input wire logic dir_fwd,
  input wire logic [1:0] rate,
  // load
  input wire logic load,
  input wire fpc_pkg::fpc_pos_t load_pos,
  // position
  output fpc_pkg::fpc_pos_t pos
);
  import fpc_pkg::*;

  fpc_pos_t next_pos;
  logic [4:0] fps;

  always_comb
  begin
    fps = fpc_fps(rate);
    next_pos = pos;
    if (dir_fwd)
    begin
      if (pos.subframes != fpc_subframes - 7'h01)
        next_pos.subframes = pos.subframes + 7'h01;
      else
      begin
        next_pos.subframes = 7'h00;
        if (pos.frames < fps - 5'h01)
          next_pos.frames = pos.frames + 5'h01;
        else
        begin
          next_pos.frames = 5'h00;
          if (pos.seconds != fpc_sec_per_min - 6'h01)
            next_pos.seconds = pos.seconds + 6'h01;
          else
          begin
            next_pos.seconds = 6'h00;
            if (pos.minutes != fpc_sec_per_min - 6'h01)
              next_pos.minutes = pos.minutes + 6'h01;
            else
            begin
              next_pos.minutes = 6'h00;
              next_pos.hours = (pos.hours == fpc_hours_per_day - 5'h01) ? 5'h00 : pos.hours + 5'h01;
            end
          end
        end
      end
    end
    else
    begin
      if (pos.subframes != 7'h00)
        next_pos.subframes = pos.subframes - 7'h01;
      else
      begin
        next_pos.subframes = fpc_subframes - 7'h01;
        if (pos.frames != 5'h00)
          next_pos.frames = pos.frames - 5'h01;
        else
        begin
          next_pos.frames = fps - 5'h01;
          if (pos.seconds != 6'h00)
            next_pos.seconds = pos.seconds - 6'h01;
          else
          begin
            next_pos.seconds = fpc_sec_per_min - 6'h01;
            if (pos.minutes != 6'h00)
              next_pos.minutes = pos.minutes - 6'h01;
            else
            begin
              next_pos.minutes = fpc_sec_per_min - 6'h01;
              next_pos.hours = (pos.hours == 5'h00) ? fpc_hours_per_day - 5'h01 : pos.hours - 5'h01;
            end
          end
        end
      end
    end
  end

  // a load takes priority over a step in the same cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pos <= '0;
    else if (load)
      pos <= load_pos;
    else if (step)
      pos <= next_pos;
  end

endmodule
`default_nettype wire

// ==== bench/fpc_checker.sv ====
/*
  Checker for fpc_top: motion gating, view changes and bus answers.
  Assumes it is bound to fpc_top and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_checker
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // motion
  input wire fpc_pkg::fpc_motion_t remote_cmd,
  input wire logic controller_attached,
  input wire logic [2:0] local_switch,
  input wire fpc_pkg::fpc_motion_t gen_cmd,
  // indicators
  input wire logic online_led,
  input wire logic report_local,
  input wire logic [1:0] reader_view,
  input wire logic subframe_blank
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // switches pass a 2-ff sync, so four settled samples are needed
  sequence offline_held_s;
    (!online_led && $stable(local_switch)) [*4];
  endsequence
  sequence offline_quiet_s;
    (!online_led && local_switch == 3'h0) [*4];
  endsequence
  local_report_a: assert property (report_local == (!online_led && controller_attached))
    else $error("local report does not match online state");
  remote_follow_a: assert property (online_led && $past(online_led) |-> gen_cmd == $past(remote_cmd))
    else $error("online generator command differs from remote command");
  remote_ignored_a: assert property (offline_quiet_s |-> gen_cmd == 4'h0)
    else $error("offline generator moved without local switches");
  local_follow_a: assert property (offline_held_s |-> gen_cmd == {|local_switch, local_switch})
    else $error("offline generator does not follow local switches");
  blank_view_a: assert property (subframe_blank |-> reader_view == 2'h1)
    else $error("subframes blanked outside film position view");
  online_key_a: assert property ($changed(online_led) |-> s_axi_bvalid)
    else $error("online state changed without a key write");
  view_step_a: assert property ($changed(reader_view) |-> s_axi_bvalid && reader_view != 2'h3)
    else $error("reader view changed badly");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not withdrawn");
endmodule
bind fpc_top fpc_checker u_chk (.mclk(mclk), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .remote_cmd(remote_cmd), .controller_attached(controller_attached),
  .local_switch(local_switch), .gen_cmd(gen_cmd), .online_led(online_led), .report_local(report_local),
  .reader_view(reader_view), .subframe_blank(subframe_blank));
`default_nettype wire

// ==== bench/fpc_remote_model.sv ====
/*
  Far side model: remote motion source and the film follower pulses.
  Assumes the bench asks for steps one cycle at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_remote_model
(
  // clock
  input wire logic mclk,
  // bench requests
  input wire fpc_pkg::fpc_motion_t cmd_req,
  input wire logic step_req,
  input wire logic step_fwd,
  input wire logic slow,
  // far-side lines
  output fpc_pkg::fpc_motion_t remote_cmd,
  output logic follower_step,
  output logic follower_dir
);
  import fpc_pkg::*;
  int cnt;
  initial
  begin
    cnt = 0;
    remote_cmd = 4'h0;
    follower_step = 1'b0;
    follower_dir = 1'b1;
  end
  always @(posedge mclk)
  begin
    remote_cmd <= cmd_req;
    // direction is a level, settled before the step edge arrives
    follower_dir <= step_fwd;
    if (step_req)
    begin
      follower_step <= 1'b1;
      cnt <= slow ? 6 : 1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
    else
      follower_step <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== bench/fpc_top_tb.sv ====
/*
  Self-checking bench for fpc_top over AXI4-Lite, with a far-side model.
  Assumes the designer's latencies; flashing is too slow to see here.
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_top_tb;
  import fpc_pkg::*;
  logic mclk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, controller_attached, follower_step;
  logic follower_dir, step_req, step_fwd, slow, online_led, set_hold_led, report_local, subframe_blank;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, reader_view, rr;
  logic [2:0] local_switch, sw;
  fpc_motion_t remote_cmd, gen_cmd, cmd_req;
  int fails, n_tests, i;
  localparam logic [31:0] dsel = 32'h0000_0003;
  fpc_top dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .remote_cmd(remote_cmd), .controller_attached(controller_attached), .local_switch(local_switch),
    .follower_step(follower_step), .follower_dir(follower_dir), .gen_cmd(gen_cmd), .online_led(online_led),
    .set_hold_led(set_hold_led), .report_local(report_local), .reader_view(reader_view),
    .subframe_blank(subframe_blank));
  fpc_remote_model model (.mclk(mclk), .cmd_req(cmd_req), .step_req(step_req), .step_fwd(step_fwd),
    .slow(slow), .remote_cmd(remote_cmd), .follower_step(follower_step), .follower_dir(follower_dir));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] pos(input logic [5:0] s, input logic [4:0] f, input logic [6:0] sub);
    return {14'h0, s, f, sub};
  endfunction
  function automatic logic [31:0] st(input logic on, input logic ed, input logic [1:0] v, input logic [1:0] fo);
    return {25'h0, fo, v, ed, ed, on};
  endfunction
  function automatic logic [4:0] rate_fps(input int r);
    return (r == 1) ? 5'h19 : (r == 2) ? 5'h1E : 5'h18;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] br;
    int n;
    n = 0;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b)
    begin
      @(negedge mclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      br = s_axi_bresp;
      @(posedge mclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      n++;
      if (n > 50)
        chk(32'h0, 32'h1);
      if (n > 50)
        tally_and_finish();
    end
    chk(32'(br), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, got;
    int n;
    n = 0;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got)
    begin
      @(negedge mclk);
      ar = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ar)
        s_axi_arvalid <= 1'b0;
      n++;
      if (n > 50)
        chk(32'h0, 32'h1);
      if (n > 50)
        tally_and_finish();
    end
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rr);
    chk(rd, exp);
  endtask
  task automatic key(input int b);
    axi_wr(fpc_reg_keys, 32'h1 << b, 2'h0);
  endtask
  task automatic step(input logic fwd, input logic slw);
    step_fwd <= fwd;
    slow <= slw;
    repeat (3) @(posedge mclk);
    step_req <= 1'b1;
    @(posedge mclk);
    step_req <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
  initial
  begin
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {controller_attached, step_req, step_fwd, slow} = 4'h0;
    local_switch = 3'h0;
    cmd_req = 4'h0;
    fails = 0;
    n_tests = 0;
    rv = $urandom(32'h5e09);
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd_chk(fpc_reg_status, st(1'b1, 1'b0, 2'h0, 2'h0));
    key(fpc_key_dsel);
    chk(32'(reader_view), 32'h0);
    for (i = 1; i <= 4; i++)
    begin
      axi_wr(fpc_reg_keys, dsel, 2'h0);
      chk(32'(reader_view), 32'(i % 3));
    end
    for (i = 0; i < 3; i++)
    begin
      axi_wr(fpc_reg_ctrl, 32'(i), 2'h0);
      axi_wr(fpc_reg_remote_pos, 32'h0, 2'h0);
      key(fpc_key_set_hold);
      chk(32'(set_hold_led), 32'h1);
      key(fpc_key_down);
      repeat (3) key(fpc_key_set_hold);
      rd_chk(fpc_reg_status, st(1'b1, 1'b1, 2'h1, 2'h3));
      key(fpc_key_up);
      repeat (2) key(fpc_key_down);
      key(fpc_key_store);
      // hours wrapped down to 23, frames up once then down twice
      rd_chk(fpc_reg_position, pos(6'h0, rate_fps(i) - 5'h1, 7'h0) | 32'h1700_0000);
      axi_rd(fpc_reg_status, rd, rr);
      chk(32'(rd[1]), 32'h0);
    end
    axi_wr(fpc_reg_remote_pos, pos(6'h0, 5'h17, 7'h63), 2'h0);
    for (i = 0; i < 3; i++)
    begin
      axi_wr(fpc_reg_ctrl, 32'(i << 2), 2'h0);
      chk(32'(subframe_blank), 32'(i == 2));
      rd_chk(fpc_reg_display, pos(6'h0, 5'h17, (i == 2) ? 7'h0 : 7'h63));
    end
    axi_wr(fpc_reg_ctrl, 32'h0, 2'h0);
    key(fpc_key_tran_mode);
    chk(32'(online_led), 32'h0);
    step(1'b1, 1'b1);
    rd_chk(fpc_reg_position, pos(6'h1, 5'h0, 7'h0));
    step(1'b0, 1'b0);
    rd_chk(fpc_reg_position, pos(6'h0, 5'h17, 7'h63));
    controller_attached <= 1'b1;
    @(posedge mclk);
    chk(32'(report_local), 32'h1);
    // random remote and local traffic, offline first, then online
    for (i = 0; i < 16; i++)
    begin
      if (i == 8)
        key(fpc_key_tran_mode);
      sw = 3'($urandom_range(7, 0));
      local_switch <= sw;
      cmd_req <= 4'($urandom);
      repeat (6) @(posedge mclk);
      if (i < 8)
        chk(32'(gen_cmd), 32'({|sw, sw}));
      else
        chk(32'(gen_cmd), 32'(cmd_req));
    end
    chk(32'(report_local), 32'h0);
    axi_wr(8'h1C, 32'h0, 2'h2);
    axi_rd(8'h18, rd, rr);
    chk({rd[29:0], rr}, 32'h2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
